// ==== sleep_wake_restart_control_tb_top.sv ====
// Purpose: Self-checking bench for the sleep, wake and restart control.
// Assumes: Second shortened to 4 oscillator ticks; processor rate 12 gives a small N.
// Notes:   Restart loads are counted at every rising clock edge so no pulse is missed.
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  $display("[ERR] %s exp %0h got %0h", nm, exp, got); n_fail++; end end
module sleep_wake_restart_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import swrc_pkg::*;
  localparam int OP_KRD = 2, OP_SAL = 3, OP_SET_CARRY_WRAP_INSTR = 4, OP_CLEAR_CARRY_WRAP_INSTR = 5, OP_SBL = 6;
  localparam int OP_RBL = 7, OP_BR = 8, OP_SDP = 9, OP_SLP = 0, OP_NOP = 11;
  localparam int PHZ = 12, THZ = 4;
  logic        clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, done, tick, clk_en, trun, pcl, add_l, br_l, carry, dp, decimal_mem_acc_op;
  logic [10:0] op;
  logic [4:0]  lines;
  logic [6:0]  pc, last_pc;
  logic [3:0]  page, last_page;
  int          n_fail = 0, comparisons = 0, n_loads = 0, n_decimal_mem_acc_op = 0, cyc = 0, l0, k;

  swrc_fw_model u_swrc_fw_model (.i_core_clk(clk), .o_op(op), .o_instr_done(done),
    .o_lines(lines), .o_osc_tick(tick));

  swrc_ctrl #(.PROC_HZ(PHZ), .TOSC_HZ(THZ)) u_swrc_ctrl (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_key_input(lines[3:0]), .i_io_line(lines[4]), .i_timer_osc_tick(tick), .i_instr_done(done),
    .i_sleep_instr(op[0]), .i_off_instr(op[1]), .i_key_read_instr(op[2]),
    .i_set_add_latch_instr(op[3]), .i_set_carry_wrap_instr(op[4]), .i_clear_carry_wrap_instr(op[5]),
    .i_set_branch_latch_instr(op[6]), .i_clear_branch_latch_instr(op[7]), .i_branch_instr(op[8]),
    .i_set_dp_instr(op[9]), .i_clear_dp_instr(op[10]), .o_proc_clk_en(clk_en), .o_timer_run(trun),
    .o_pc_load(pcl), .o_program_counter(pc), .o_page(page), .o_add_latch(add_l),
    .o_branch_latch(br_l), .o_carry_wrap(carry), .o_decimal_point(dp), .o_decimal_mem_acc_op(decimal_mem_acc_op));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic int n_min(input int p, input int t);
    return (4 * p + 6 * t - 1) / (6 * t) + 1;
  endfunction : n_min

  function automatic logic [31:0] time_exp(input int n);
    return 32'((n % THZ) << SWRC_TIME_SUB_LSB) | 32'((n / THZ) % 16);
  endfunction : time_exp

  task automatic wrap_up();
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Hang guard: the whole run needs a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  always @(posedge clk) begin
    if (pcl === 1'b1) begin
      n_loads++;
      last_pc = pc;
      last_page = page;
    end
    if (decimal_mem_acc_op === 1'b1) n_decimal_mem_acc_op++;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Timer runs unsynchronised: repeat until two reads agree
  task automatic rd_time(output logic [31:0] v);
    logic [31:0] a;
    apb(1'b0, SWRC_TIME_OFS, '0, v);
    repeat (4) begin
      a = v;
      apb(1'b0, SWRC_TIME_OFS, '0, v);
      if (v === a) break;
    end
  endtask : rd_time

  task automatic chk_wake(input int base);
    `CHK("wake_cnt", base + 1, n_loads);
    `CHK("wake_pc", SWRC_PC_WAKE, last_pc);
    `CHK("wake_page", SWRC_RESTART_PAGE, last_page);
    `CHK("run_clk", 1'b1, clk_en);
  endtask : chk_wake

  task automatic key_cycle(input int gap, input logic off, input logic [4:0] pre, input logic [4:0] hit,
                           input logic exp);
    int b;
    u_swrc_fw_model.set_lines(pre);
    u_swrc_fw_model.go_sleep(gap, off);
    `CHK("asleep", 1'b0, clk_en);
    `CHK("timer_run", ~off, trun);
    b = n_loads;
    u_swrc_fw_model.set_lines(hit);
    repeat (4) @(posedge clk);
    if (exp) begin
      chk_wake(b);
      `CHK("add_clr", 1'b0, add_l);
      `CHK("br_clr", 1'b0, br_l);
      `CHK("dp_clr", 1'b0, dp);
    end else begin
      `CHK("no_wake", b, n_loads);
    end
  endtask : key_cycle

  initial begin
    void'($urandom(32'h9E9375A7));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK("cold_cnt", 1, n_loads);
    `CHK("cold_pc", SWRC_PC_COLD, last_pc);
    `CHK("cold_page", SWRC_RESTART_PAGE, last_page);
    apb(1'b0, SWRC_CTRL_OFS, '0, rd);
    `CHK("ctrl_rst", SWRC_CTRL_RST, rd[1:0]);
    apb(1'b0, 8'h10, '0, rd);
    `CHK("unmapped", 1'b1, err);
    u_swrc_fw_model.instr(OP_SAL);
    apb(1'b0, SWRC_STAT_OFS, '0, rd);
    `CHK("suspect", 2'h3, {rd[6], rd[3]});
    u_swrc_fw_model.instr(OP_SET_CARRY_WRAP_INSTR);
    apb(1'b0, SWRC_STAT_OFS, '0, rd);
    `CHK("forced_set", 2'h1, {rd[6], carry});
    u_swrc_fw_model.instr(OP_CLEAR_CARRY_WRAP_INSTR);
    `CHK("forced_clr", 1'b0, carry);
    u_swrc_fw_model.instr(OP_SDP);
    u_swrc_fw_model.instr(OP_SBL);
    u_swrc_fw_model.instr(OP_BR);
    @(posedge clk);
    `CHK("dec_op", 1, n_decimal_mem_acc_op);
    u_swrc_fw_model.instr(OP_NOP);
    apb(1'b0, SWRC_STAT_OFS, '0, rd);
    `CHK("misuse", 1'b1, rd[SWRC_STAT_MISUSE]);
    apb(1'b1, SWRC_STAT_OFS, 32'h0000_0100, rd);
    apb(1'b0, SWRC_STAT_OFS, '0, rd);
    `CHK("misuse_w1c", 1'b0, rd[SWRC_STAT_MISUSE]);
    u_swrc_fw_model.instr(OP_RBL);
    `CHK("br_off", 1'b0, br_l);
    u_swrc_fw_model.instr(OP_SBL);
    key_cycle(3, 1'b0, '0, 5'($urandom_range(1, 31)), 1'b1);
    key_cycle(4, 1'b0, '0, 5'($urandom_range(1, 31)), 1'b0);
    l0 = n_loads;
    u_swrc_fw_model.tick(THZ);
    repeat (3) @(posedge clk);
    chk_wake(l0);
    apb(1'b0, SWRC_GAP_OFS, '0, rd);
    `CHK("gap_min", 8'(n_min(PHZ, THZ)), rd[15:8]);
    u_swrc_fw_model.instr(OP_SLP);
    `CHK("sleep_held", 1'b1, clk_en);
    repeat (n_min(PHZ, THZ)) u_swrc_fw_model.instr(OP_NOP);
    repeat (2) @(posedge clk);
    `CHK("sleep_late", 1'b0, clk_en);
    l0 = n_loads;
    u_swrc_fw_model.tick(THZ);
    repeat (3) @(posedge clk);
    chk_wake(l0);
    repeat (n_min(PHZ, THZ)) u_swrc_fw_model.instr(OP_NOP);
    apb(1'b1, SWRC_CTRL_OFS, 32'h0000_0002, rd);
    apb(1'b0, SWRC_CTRL_OFS, '0, rd);
    `CHK("ctrl_wr", 2'h2, rd[1:0]);
    key_cycle(1, 1'b0, 5'h01, 5'h03, 1'b0);
    l0 = n_loads;
    u_swrc_fw_model.tick(THZ);
    repeat (3) @(posedge clk);
    `CHK("twake_off", l0, n_loads);
    u_swrc_fw_model.set_lines('0);
    u_swrc_fw_model.set_lines(5'h10);
    repeat (3) @(posedge clk);
    chk_wake(l0);
    key_cycle(0, 1'b1, '0, 5'($urandom_range(1, 31)), 1'b1);
    k = $urandom_range(64, 90);
    u_swrc_fw_model.tick(k);
    rd_time(rd);
    `CHK("time_wrap", time_exp(k), rd);
    wrap_up();
  end
endmodule : sleep_wake_restart_control_tb_top
`undef CHK
`default_nettype wire

// ==== swrc_ctrl.sv ====
// Purpose: Sleep, off, wake and restart control with APB status and setup.
// Assumes: Core strobes are one-cycle pulses, one per executed instruction.
// Notes:   Timer value is read unsynchronised to firmware; read it twice.
//
// Chosen here: the APB slave port and the register offsets.
`default_nettype none
// How it works
// - Wake only on rise after all lines low
// - Power-up fetch starts page 15, counter zero
// - Wake restarts page 15, counter 7F
// - Seconds counter wraps modulo sixteen
// - Latch-set may corrupt carry; force it after
// - Timer reads may tear; repeat until equal
// - Minimum instructions after timer wake before sleep
// - Branch with branch latch does decimal op
// - Only branches while branch latch set; clear it
// - Wake clears add, branch, point; keeps rest
// - Key read within three instructions of sleep
module swrc_ctrl
  import swrc_pkg::*;
#(
  parameter int PROC_HZ = SWRC_PROC_HZ,
  parameter int TOSC_HZ = SWRC_TOSC_HZ
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [3:0]  i_key_input,
  input  wire logic        i_io_line,
  input  wire logic        i_timer_osc_tick,
  input  wire logic        i_instr_done,
  input  wire logic        i_sleep_instr,
  input  wire logic        i_off_instr,
  input  wire logic        i_key_read_instr,
  input  wire logic        i_set_add_latch_instr,
  input  wire logic        i_set_carry_wrap_instr,
  input  wire logic        i_clear_carry_wrap_instr,
  input  wire logic        i_set_branch_latch_instr,
  input  wire logic        i_clear_branch_latch_instr,
  input  wire logic        i_branch_instr,
  input  wire logic        i_set_dp_instr,
  input  wire logic        i_clear_dp_instr,
  output logic             o_proc_clk_en,
  output logic             o_timer_run,
  output logic             o_pc_load,
  output logic [6:0]       o_program_counter,
  output logic [3:0]       o_page,
  output logic             o_add_latch,
  output logic             o_branch_latch,
  output logic             o_carry_wrap,
  output logic             o_decimal_point,
  output logic             o_decimal_mem_acc_op
);
  localparam longint MIN_L   = (4 * longint'(PROC_HZ) + 6 * longint'(TOSC_HZ) - 1)
                               / (6 * longint'(TOSC_HZ)) + 1;
  localparam int     SW      = $clog2(TOSC_HZ);
  localparam logic [7:0] MIN_INSTR = 8'(MIN_L);

  generate
    if (MIN_L < 1 || MIN_L > 255 || TOSC_HZ < 2) begin : g_bad
      $error("PROC_HZ / TOSC_HZ give an unusable instruction minimum");
    end
  endgenerate

  swrc_state_e state_ff;
  swrc_state_e nxt_state;
  logic [1:0]  ctrl_ff;
  logic        boot_ff;
  logic        pc_load_ff;
  logic [6:0]  pc_ff;
  logic        add_ff;
  logic        branch_ff;
  logic        carry_ff;
  logic        suspect_ff;
  logic        dp_ff;
  logic        dec_op_ff;
  logic        misuse_ff;
  logic        twoke_ff;
  logic        kwake_ff;
  logic [2:0]  kgap_ff;
  logic [7:0]  tgap_ff;
  logic        pend_ff;
  logic [31:0] prdata_ff;
  logic        wake_key;
  logic        wake_any;
  logic        armed;
  logic        sec_tick;
  logic [3:0]  seconds;
  logic [SW-1:0] sub;
  logic        sleep_req;
  logic        sleep_ok;
  logic        wr_acc;
  logic        rd_setup;
  logic        misuse_set;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == SWRC_CTRL_OFS) || (a == SWRC_STAT_OFS) ||
              (a == SWRC_TIME_OFS) || (a == SWRC_GAP_OFS);
  endfunction : addr_ok

  swrc_wake_det u_wake (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_enable   (state_ff != SWRC_RUN && kwake_ff),
    .i_lines    ({i_io_line, i_key_input}),
    .o_armed    (armed),
    .o_wake     (wake_key)
  );

  swrc_timer #(.TICKS_PER_SEC(TOSC_HZ), .SW(SW)) u_timer (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_run      (state_ff != SWRC_OFF),
    .i_clear    (state_ff == SWRC_OFF),
    .i_osc_tick (i_timer_osc_tick),
    .o_seconds  (seconds),
    .o_sub      (sub),
    .o_sec_tick (sec_tick)
  );

  // Timer wake only from sleep; the timer is stopped when off
  assign wake_any  = wake_key || (state_ff == SWRC_SLEEP && sec_tick && ctrl_ff[SWRC_CTRL_TWAKE]);
  assign sleep_req = i_sleep_instr || pend_ff;
  assign sleep_ok  = !twoke_ff || (tgap_ff >= MIN_INSTR);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SWRC_RUN: begin
        if (i_off_instr) begin
          nxt_state = SWRC_OFF;
        end else if (sleep_req && sleep_ok) begin
          nxt_state = SWRC_SLEEP;
        end
      end
      SWRC_SLEEP, SWRC_OFF: begin
        if (wake_any) begin
          nxt_state = SWRC_RUN;
        end
      end
      default: begin
        nxt_state = SWRC_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff <= SWRC_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Sleep held back until enough instructions ran after a timer wake
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pend_ff <= 1'b0;
    end else begin
      pend_ff <= (state_ff == SWRC_RUN) && sleep_req && !sleep_ok && !i_off_instr;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      twoke_ff <= 1'b0;
      tgap_ff  <= 8'h00;
    end else if (state_ff != SWRC_RUN && wake_any) begin
      twoke_ff <= !wake_key;
      tgap_ff  <= 8'h00;
    end else if (i_instr_done && tgap_ff != 8'hFF) begin
      tgap_ff  <= tgap_ff + 8'h01;
    end
  end

  // Gap saturates at four, meaning too far for a key wake
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kgap_ff <= 3'h4;
    end else if (i_key_read_instr) begin
      kgap_ff <= 3'h0;
    end else if (i_instr_done && kgap_ff <= SWRC_KEY_GAP_MAX) begin
      kgap_ff <= kgap_ff + 3'h1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      kwake_ff <= 1'b0;
    end else if (state_ff == SWRC_RUN) begin
      kwake_ff <= ctrl_ff[SWRC_CTRL_KWAKE] && (kgap_ff <= SWRC_KEY_GAP_MAX);
    end
  end

  // Restart vector: cold start once after reset, wake vector after each wake
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_ff    <= 1'b0;
      pc_load_ff <= 1'b0;
      pc_ff      <= SWRC_PC_COLD;
    end else begin
      boot_ff    <= 1'b1;
      pc_load_ff <= !boot_ff || (state_ff != SWRC_RUN && wake_any);
      if (!boot_ff) begin
        pc_ff <= SWRC_PC_COLD;
      end else if (state_ff != SWRC_RUN && wake_any) begin
        pc_ff <= SWRC_PC_WAKE;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      add_ff <= 1'b0;
      dp_ff  <= 1'b0;
    end else if (state_ff != SWRC_RUN && wake_any) begin
      add_ff <= 1'b0;
      dp_ff  <= 1'b0;
    end else begin
      add_ff <= add_ff || i_set_add_latch_instr;
      dp_ff  <= i_set_dp_instr || (dp_ff && !i_clear_dp_instr);
    end
  end

  // Carry marked suspect after latch set until firmware forces it
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      carry_ff   <= 1'b0;
      suspect_ff <= 1'b0;
    end else begin
      if (i_set_carry_wrap_instr) begin
        carry_ff <= 1'b1;
      end else if (i_clear_carry_wrap_instr) begin
        carry_ff <= 1'b0;
      end
      suspect_ff <= i_set_add_latch_instr ||
                    (suspect_ff && !i_set_carry_wrap_instr && !i_clear_carry_wrap_instr);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      branch_ff <= 1'b0;
      dec_op_ff <= 1'b0;
    end else begin
      branch_ff <= !(state_ff != SWRC_RUN && wake_any) && !i_clear_branch_latch_instr &&
                   (branch_ff || i_set_branch_latch_instr);
      dec_op_ff <= i_branch_instr && branch_ff;
    end
  end

  // Non-branch work under the branch latch is flagged; set wins over clear
  assign misuse_set = i_instr_done && branch_ff && !i_branch_instr && !i_clear_branch_latch_instr;
  assign wr_acc     = i_psel && i_penable && i_pwrite;
  assign rd_setup   = i_psel && !i_penable && !i_pwrite;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      misuse_ff <= 1'b0;
    end else if (misuse_set) begin
      misuse_ff <= 1'b1;
    end else if (wr_acc && i_paddr == SWRC_STAT_OFS && i_pwdata[SWRC_STAT_MISUSE]) begin
      misuse_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_ff <= SWRC_CTRL_RST;
    end else if (wr_acc && i_paddr == SWRC_CTRL_OFS) begin
      ctrl_ff <= i_pwdata[1:0];
    end
  end

  // Read data captured in setup so the access phase answers at once
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prdata_ff <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_ff <= 32'h0000_0000;
      case (i_paddr)
        SWRC_CTRL_OFS: prdata_ff[1:0] <= ctrl_ff;
        SWRC_STAT_OFS: prdata_ff[10:0] <= {armed, twoke_ff, misuse_ff, dp_ff, suspect_ff,
                                           carry_ff, branch_ff, add_ff, state_ff};
        SWRC_TIME_OFS: prdata_ff[SWRC_TIME_SUB_LSB + SW - 1:0] <= {sub, seconds};
        SWRC_GAP_OFS:  prdata_ff[15:0] <= {MIN_INSTR, tgap_ff};
        default:       prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  assign o_prdata             = prdata_ff;
  assign o_pready             = 1'b1;
  assign o_pslverr            = i_psel && i_penable && !addr_ok(i_paddr);
  assign o_proc_clk_en        = (state_ff == SWRC_RUN);
  assign o_timer_run          = (state_ff != SWRC_OFF);
  assign o_pc_load            = pc_load_ff;
  assign o_program_counter    = pc_ff;
  assign o_page               = SWRC_RESTART_PAGE;
  assign o_add_latch          = add_ff;
  assign o_branch_latch       = branch_ff;
  assign o_carry_wrap         = carry_ff;
  assign o_decimal_point      = dp_ff;
  assign o_decimal_mem_acc_op = dec_op_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_wake_seen;
    state_ff != SWRC_RUN && wake_any;
  endsequence
  sequence s_restart;
    o_pc_load && o_program_counter == SWRC_PC_WAKE && state_ff == SWRC_RUN;
  endsequence

  a_cold_vector: assert property ($rose(boot_ff) |-> o_pc_load && o_program_counter == SWRC_PC_COLD
                                  && o_page == SWRC_RESTART_PAGE)
    else $error("cold start vector wrong");
  a_wake_vector: assert property (s_wake_seen |=> s_restart)
    else $error("wake restart vector wrong");
  a_wake_clears: assert property (s_wake_seen |=> !add_ff && !branch_ff && !dp_ff)
    else $error("latches not cleared on wake");
  a_carry_force: assert property (i_clear_carry_wrap_instr && !i_set_carry_wrap_instr
                                  && !i_set_add_latch_instr |=> !o_carry_wrap && !suspect_ff)
    else $error("carry not forced after latch set");
  a_timer_read: assert property (rd_setup && i_paddr == SWRC_TIME_OFS |=>
                                 o_prdata[3:0] == $past(seconds))
    else $error("timer read value wrong");
  a_min_gap: assert property ((state_ff == SWRC_RUN ##1 state_ff == SWRC_SLEEP) |->
                              $past(sleep_ok))
    else $error("sleep too soon after timer wake");
  a_dec_op: assert property (i_branch_instr && branch_ff |=> o_decimal_mem_acc_op)
    else $error("decimal op missing");
  a_misuse: assert property (misuse_set |=> misuse_ff)
    else $error("branch latch misuse not flagged");
  a_key_gap: assert property ((state_ff == SWRC_RUN ##1 state_ff != SWRC_RUN && kwake_ff) |->
                              $past(kgap_ff) <= SWRC_KEY_GAP_MAX)
    else $error("key wake enabled after late key read");
  a_sleep_clk: assert property (state_ff == SWRC_SLEEP |-> !o_proc_clk_en && o_timer_run)
    else $error("sleep clock gating wrong");
  a_off_clk: assert property (state_ff == SWRC_OFF |-> !o_proc_clk_en && !o_timer_run)
    else $error("off mode gating wrong");
endmodule : swrc_ctrl
`default_nettype wire

// ==== swrc_fw_model.sv ====
// Purpose: Firmware and wake-line model driving the core strobes of the sleep control.
// Assumes: One instruction is a one-cycle strobe with its done pulse, then one idle cycle.
// Notes:   Key and port lines idle low, as with the pull-down option.
`default_nettype none
module swrc_fw_model (
  input  wire logic        i_core_clk,
  output var  logic [10:0] o_op,
  output var  logic        o_instr_done,
  output var  logic [4:0]  o_lines,
  output var  logic        o_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int OP_SLP = 0;
  localparam int OP_OFF = 1;
  localparam int OP_KRD = 2;
  localparam int OP_NOP = 11;

  initial begin
    o_op         = '0;
    o_instr_done = 1'b0;
    o_lines      = '0;
    o_osc_tick   = 1'b0;
  end

  // Codes above ten carry no strobe: a plain instruction
  task automatic instr(input int code);
    o_op         <= (code < 11) ? (11'h001 << code) : 11'h000;
    o_instr_done <= 1'b1;
    @(posedge i_core_clk);
    o_op         <= '0;
    o_instr_done <= 1'b0;
    @(posedge i_core_clk);
  endtask : instr

  task automatic set_lines(input logic [4:0] v);
    o_lines <= v;
    @(posedge i_core_clk);
  endtask : set_lines

  // Key read, gap instructions, then sleep or off
  task automatic go_sleep(input int gap, input logic off);
    instr(OP_KRD);
    repeat (gap) instr(OP_NOP);
    instr(off ? OP_OFF : OP_SLP);
  endtask : go_sleep

  task automatic tick(input int n);
    repeat (n) begin
      o_osc_tick <= 1'b1;
      @(posedge i_core_clk);
      o_osc_tick <= 1'b0;
      @(posedge i_core_clk);
    end
  endtask : tick
endmodule : swrc_fw_model
`default_nettype wire

// ==== swrc_pkg.sv ====
// Purpose: Shared constants and types for the sleep, wake and restart control.
// Assumes: One core clock; all pins and core strobes are synchronous to it.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
`default_nettype none
package swrc_pkg;
  localparam logic [7:0] SWRC_CTRL_OFS     = 8'h00;
  localparam logic [7:0] SWRC_STAT_OFS     = 8'h04;
  localparam logic [7:0] SWRC_TIME_OFS     = 8'h08;
  localparam logic [7:0] SWRC_GAP_OFS      = 8'h0C;
  localparam int         SWRC_CTRL_TWAKE   = 0;
  localparam int         SWRC_CTRL_KWAKE   = 1;
  localparam logic [1:0] SWRC_CTRL_RST     = 2'h3;
  localparam int         SWRC_STAT_MISUSE  = 8;
  localparam int         SWRC_TIME_SUB_LSB = 4;
  localparam int         SWRC_GAP_MIN_LSB  = 8;
  localparam logic [3:0] SWRC_RESTART_PAGE = 4'hF;
  localparam logic [6:0] SWRC_PC_COLD      = 7'h00;
  localparam logic [6:0] SWRC_PC_WAKE      = 7'h7F;
  localparam logic [2:0] SWRC_KEY_GAP_MAX  = 3'h3;
  localparam int         SWRC_TOSC_HZ      = 32768;
  localparam int         SWRC_PROC_HZ      = 1100000;
  typedef enum logic [2:0] {
    SWRC_RUN   = 3'h1,
    SWRC_SLEEP = 3'h2,
    SWRC_OFF   = 3'h4
  } swrc_state_e;
endpackage : swrc_pkg
`default_nettype wire

// ==== swrc_timer.sv ====
// Purpose: Timekeeping counter, seconds modulo sixteen.
// Assumes: i_osc_tick is one core cycle per timer oscillator period.
// Notes:   Counts only while i_run; i_clear wins over counting.
`default_nettype none
module swrc_timer
  import swrc_pkg::*;
#(
  parameter int TICKS_PER_SEC = SWRC_TOSC_HZ,
  parameter int SW            = $clog2(TICKS_PER_SEC)
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_run,
  input  wire logic          i_clear,
  input  wire logic          i_osc_tick,
  output logic [3:0]         o_seconds,
  output logic [SW-1:0]      o_sub,
  output logic               o_sec_tick
);
  localparam logic [SW-1:0] SUB_LAST = SW'(TICKS_PER_SEC - 1);

  generate
    if (TICKS_PER_SEC < 2 || SW > 27) begin : g_bad
      $error("TICKS_PER_SEC out of range");
    end
  endgenerate

  logic [SW-1:0] sub_ff;
  logic [3:0]    sec_ff;
  logic          tick_ff;
  logic          roll;

  assign roll = i_run && i_osc_tick && (sub_ff == SUB_LAST);

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sub_ff <= '0;
      sec_ff <= 4'h0;
    end else if (i_clear) begin
      sub_ff <= '0;
      sec_ff <= 4'h0;
    end else if (roll) begin
      sub_ff <= '0;
      sec_ff <= sec_ff + 4'h1;
    end else if (i_run && i_osc_tick) begin
      sub_ff <= sub_ff + SW'(1);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= roll && !i_clear;
    end
  end

  assign o_seconds  = sec_ff;
  assign o_sub      = sub_ff;
  assign o_sec_tick = tick_ff;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  a_sec_wrap16: assert property ((sec_ff == 4'hF && roll && !i_clear) |=> sec_ff == 4'h0)
    else $error("seconds did not wrap to zero");
  a_stop_holds: assert property (!i_run |=> ($stable(sec_ff) && $stable(sub_ff)) ||
                                 (sec_ff == 4'h0 && sub_ff == '0))
    else $error("timer moved while stopped");
endmodule : swrc_timer
`default_nettype wire

// ==== swrc_wake_det.sv ====
// Purpose: Wake detector on the four key lines and the port line.
// Assumes: Lines are synchronous to the core clock.
// Notes:   Arms only after every line was seen low.
`default_nettype none
module swrc_wake_det
  import swrc_pkg::*;
(
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_enable,
  input  wire logic [4:0] i_lines,
  output logic            o_armed,
  output logic            o_wake
);
  logic armed_ff;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      armed_ff <= 1'b0;
    end else begin
      armed_ff <= i_enable && (i_lines == 5'h00);
    end
  end

  assign o_armed = armed_ff;
  assign o_wake  = i_enable && armed_ff && (|i_lines);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  a_wake_after_low: assert property (o_wake |-> $past(i_lines) == 5'h00)
    else $error("wake without all lines low before");
endmodule : swrc_wake_det
`default_nettype wire
